// ### logic/dscb_config_bank.v
// Serial configuration register bank with a two-wire slave port.
// Assumes SCL and SDA are already synchronous to clk and glitch free.
`timescale 1ns/10ps
`default_nettype none
`include "dscb_defs.vh"

// Summary of operation
// - Register 0 resets zero; value 0x01 lets registers override pins except address.
// - Pin-strapped bus address is one of four values picked by the address select pin.
// - Transactions open with START or repeated START and close with STOP.
// - SDA rising while SCL high is STOP; slave returns idle.
// - Acknowledge the address byte only when it matches our own address.
// - Acknowledge every data byte the master writes.
// - Slave stays silent for 10 ms after power-up.
// - Register 1 bit 7 picks pin address or the register's bits 6:0.
// - Mode field bits 3:2 or pin pair selects normal or compatibility mode.
// - Register 0 bit 7 picks low spread-spectrum frequency range.
// - Register 0 bits 6 and 5 boost clock and data slew.
// - Register 0 bit 4 picks rising or falling strobe edge.
// - Register 0 bit 1 enters sleep, keeping register contents.
// - Register 2 bit 7 releases hold-low, only while the link is acquired.
// - Register 2 bit 6 picks driven-low or high-impedance sleep outputs.
// - Register 2 bits 5:4 set LSB mapping in compatibility mode.
// - Register 2 bit 3 bypasses the strap's hold-low enable.
// - Register 3 bits 7:5 select receive equalization gain.
// - Register 3 bit 4 switches receive equalization on.
module dscb_config_bank #(
	parameter PWRUP_CYCLES = (`DSCB_CLK_HZ / 1000) * `DSCB_PWRUP_MS
) (
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Serial bus pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	// Strap and control pins
	input wire [1:0] address_select_pin,
	input wire [1:0] mode_pin,
	input wire low_freq_spread_range_pin,
	input wire clock_out_slew_boost_pin,
	input wire data_out_slew_boost_pin,
	input wire strobe_edge_select_pin,
	input wire sleep_output_state_select_pin,
	input wire [1:0] map_select_pin,
	input wire output_hold_low_strap,
	input wire [2:0] free_clock_select_pin,
	input wire link_acquired,
	// Effective settings
	output reg [1:0] mode,
	output reg low_freq_spread_range,
	output reg clock_out_slew_boost,
	output reg data_out_slew_boost,
	output reg strobe_edge_select,
	output reg sleep_mode,
	output reg outputs_held_low,
	output reg sleep_output_state_select,
	output reg [1:0] lsb_map_select,
	output reg [2:0] free_clock_select,
	output reg [2:0] receive_boost_level,
	output reg receive_boost_enable,
	output reg [6:0] bus_address
);

	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_AACK = 3'd2;
	localparam ST_WDATA = 3'd3;
	localparam ST_WACK = 3'd4;
	localparam ST_RDATA = 3'd5;
	localparam ST_RACK = 3'd6;
	localparam ST_BEGIN = 3'd7;

	reg [7:0] cfg_one_r;
	reg [7:0] addr_sel_r;
	reg [7:0] feat_one_r;
	reg [7:0] feat_two_r;
	reg [2:0] state_r;
	reg [2:0] bit_cnt_r;
	reg [7:0] shift_r;
	reg [7:0] offset_r;
	reg have_offset_r;
	reg rw_r;
	reg sda_drive_r;
	reg scl_d_r;
	reg sda_d_r;
	reg [31:0] pwr_cnt_r;
	reg ready_r;
	reg hold_rel_d_r;
	reg link_d_r;
	reg hold_low_r;
	reg [6:0] pin_addr;
	reg [7:0] rd_data;
	wire scl_rise = scl_in & ~scl_d_r;
	wire scl_fall = ~scl_in & scl_d_r;
	wire start_cond = scl_in & scl_d_r & sda_d_r & ~sda_in;
	wire stop_cond = scl_in & scl_d_r & ~sda_d_r & sda_in;
	wire regs_on = cfg_one_r[`DSCB_BIT_OVERRIDE];

	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = sda_drive_r;

	always @*
	begin
		case (address_select_pin)
			2'd0: pin_addr = `DSCB_ADDR_0;
			2'd1: pin_addr = `DSCB_ADDR_1;
			2'd2: pin_addr = `DSCB_ADDR_2;
			default: pin_addr = `DSCB_ADDR_3;
		endcase
		case (offset_r)
			`DSCB_OFS_CONFIG_ONE: rd_data = cfg_one_r;
			`DSCB_OFS_ADDR_SEL: rd_data = addr_sel_r;
			`DSCB_OFS_FEAT_ONE: rd_data = feat_one_r;
			`DSCB_OFS_FEAT_TWO: rd_data = feat_two_r;
			default: rd_data = 8'h00;
		endcase
	end

	// Address source, independent of the override bit
	always @(posedge clk)
	begin
		if (sys_rst)
			bus_address <= `DSCB_ADDR_0;
		else if (addr_sel_r[`DSCB_BIT_ADDR_SRC])
			bus_address <= addr_sel_r[6:0];
		else
			bus_address <= pin_addr;
	end

	// Quiet period after power-up; host must also wait it out
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			pwr_cnt_r <= 32'h00000000;
			ready_r <= 1'b0;
		end
		else if (!ready_r)
		begin
			pwr_cnt_r <= pwr_cnt_r + 32'h00000001;
			ready_r <= (pwr_cnt_r >= PWRUP_CYCLES - 1);
		end
	end

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			state_r <= ST_IDLE;
			bit_cnt_r <= 3'd0;
			shift_r <= 8'h00;
			offset_r <= 8'h00;
			have_offset_r <= 1'b0;
			rw_r <= 1'b0;
			sda_drive_r <= 1'b0;
			cfg_one_r <= `DSCB_RST_CONFIG_ONE;
			addr_sel_r <= `DSCB_RST_ADDR_SEL;
			feat_one_r <= `DSCB_RST_FEAT_ONE;
			feat_two_r <= `DSCB_RST_FEAT_TWO;
		end
		else
		begin
			scl_d_r <= scl_in;
			sda_d_r <= sda_in;
			if (!ready_r)
			begin
				state_r <= ST_IDLE;
				sda_drive_r <= 1'b0;
			end
			else if (stop_cond)
			begin
				state_r <= ST_IDLE;
				sda_drive_r <= 1'b0;
			end
			else if (start_cond)
			begin
				state_r <= ST_BEGIN;
				bit_cnt_r <= 3'd0;
				sda_drive_r <= 1'b0;
			end
			else
			begin
				case (state_r)
					ST_ADDR, ST_WDATA:
						if (scl_rise)
						begin
							shift_r <= {shift_r[6:0], sda_in};
							bit_cnt_r <= bit_cnt_r + 3'd1;
						end
						else if (scl_fall && bit_cnt_r == 3'd0)
						begin
							if (state_r == ST_ADDR)
							begin
								rw_r <= shift_r[0];
								have_offset_r <= 1'b0;
								if (shift_r[7:1] == bus_address)
								begin
									sda_drive_r <= 1'b1;
									state_r <= ST_AACK;
								end
								else
									state_r <= ST_IDLE;
							end
							else
							begin
								sda_drive_r <= 1'b1;
								state_r <= ST_WACK;
								if (!have_offset_r)
								begin
									offset_r <= shift_r;
									have_offset_r <= 1'b1;
								end
								else
								begin
									case (offset_r)
										`DSCB_OFS_CONFIG_ONE: cfg_one_r <= shift_r;
										`DSCB_OFS_ADDR_SEL: addr_sel_r <= shift_r;
										`DSCB_OFS_FEAT_ONE: feat_one_r <= shift_r;
										`DSCB_OFS_FEAT_TWO: feat_two_r <= shift_r;
										default: ;
									endcase
									offset_r <= offset_r + 8'h01;
								end
							end
						end
					ST_AACK:
						if (scl_fall)
						begin
							bit_cnt_r <= 3'd0;
							if (rw_r)
							begin
								shift_r <= rd_data;
								sda_drive_r <= ~rd_data[7];
								state_r <= ST_RDATA;
							end
							else
							begin
								sda_drive_r <= 1'b0;
								state_r <= ST_WDATA;
							end
						end
					ST_WACK:
						if (scl_fall)
						begin
							sda_drive_r <= 1'b0;
							bit_cnt_r <= 3'd0;
							state_r <= ST_WDATA;
						end
					ST_RDATA:
						if (scl_fall)
						begin
							bit_cnt_r <= bit_cnt_r + 3'd1;
							if (bit_cnt_r == 3'd7)
							begin
								sda_drive_r <= 1'b0;
								offset_r <= offset_r + 8'h01;
								state_r <= ST_RACK;
							end
							else
							begin
								sda_drive_r <= ~shift_r[6];
								shift_r <= {shift_r[6:0], 1'b0};
							end
						end
					ST_RACK:
						if (scl_rise)
						begin
							if (sda_in)
								state_r <= ST_IDLE;
						end
						else if (scl_fall)
						begin
							bit_cnt_r <= 3'd0;
							shift_r <= rd_data;
							sda_drive_r <= ~rd_data[7];
							state_r <= ST_RDATA;
						end
					ST_BEGIN:
						if (scl_fall)
							state_r <= ST_ADDR;
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Hold-low latch: release needs a 0-to-1 write while link is up
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			hold_low_r <= 1'b1;
			hold_rel_d_r <= 1'b0;
			link_d_r <= 1'b0;
		end
		else
		begin
			hold_rel_d_r <= feat_one_r[`DSCB_BIT_HOLD_REL];
			link_d_r <= link_acquired;
			if (link_d_r && !link_acquired)
				hold_low_r <= 1'b1;
			else if (link_acquired && feat_one_r[`DSCB_BIT_HOLD_REL] && !hold_rel_d_r)
				hold_low_r <= 1'b0;
			else if (link_acquired && !feat_one_r[`DSCB_BIT_HOLD_REL] && hold_rel_d_r)
				hold_low_r <= 1'b1;
		end
	end

	// Effective settings: registers win only when override is on
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			mode <= 2'b00;
			low_freq_spread_range <= 1'b0;
			clock_out_slew_boost <= 1'b0;
			data_out_slew_boost <= 1'b0;
			strobe_edge_select <= 1'b0;
			sleep_mode <= 1'b0;
			outputs_held_low <= 1'b0;
			sleep_output_state_select <= 1'b0;
			lsb_map_select <= 2'b00;
			free_clock_select <= 3'd0;
			receive_boost_level <= 3'd0;
			receive_boost_enable <= 1'b0;
		end
		else if (regs_on)
		begin
			mode <= cfg_one_r[`DSCB_MODE_HI:`DSCB_MODE_LO];
			low_freq_spread_range <= cfg_one_r[`DSCB_BIT_LOW_FREQ];
			clock_out_slew_boost <= cfg_one_r[`DSCB_BIT_CLK_SLEW];
			data_out_slew_boost <= cfg_one_r[`DSCB_BIT_DATA_SLEW];
			strobe_edge_select <= cfg_one_r[`DSCB_BIT_STROBE];
			sleep_mode <= cfg_one_r[`DSCB_BIT_SLEEP];
			outputs_held_low <= output_hold_low_strap &
				~feat_one_r[`DSCB_BIT_HOLD_BYPASS] & hold_low_r;
			sleep_output_state_select <= feat_one_r[`DSCB_BIT_SLEEP_STATE];
			lsb_map_select <= feat_one_r[`DSCB_MAP_HI:`DSCB_MAP_LO];
			free_clock_select <= feat_one_r[`DSCB_FCLK_HI:0];
			receive_boost_level <= feat_two_r[`DSCB_EQ_HI:`DSCB_EQ_LO];
			receive_boost_enable <= feat_two_r[`DSCB_BIT_EQ_EN];
		end
		else
		begin
			mode <= mode_pin;
			low_freq_spread_range <= low_freq_spread_range_pin;
			clock_out_slew_boost <= clock_out_slew_boost_pin;
			data_out_slew_boost <= data_out_slew_boost_pin;
			strobe_edge_select <= strobe_edge_select_pin;
			sleep_mode <= 1'b0;
			outputs_held_low <= output_hold_low_strap & hold_low_r;
			sleep_output_state_select <= sleep_output_state_select_pin;
			lsb_map_select <= map_select_pin;
			free_clock_select <= free_clock_select_pin;
			receive_boost_level <= 3'd0;
			receive_boost_enable <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ### include/dscb_defs.vh
// Constants for the deserializer serial configuration bank.
// Assumes inclusion by bare name from the design file.
`ifndef DSCB_DEFS_VH
`define DSCB_DEFS_VH

// Register offsets
`define DSCB_OFS_CONFIG_ONE 8'h00
`define DSCB_OFS_ADDR_SEL 8'h01
`define DSCB_OFS_FEAT_ONE 8'h02
`define DSCB_OFS_FEAT_TWO 8'h03

// Reset values
`define DSCB_RST_CONFIG_ONE 8'h00
`define DSCB_RST_ADDR_SEL 8'h70
`define DSCB_RST_FEAT_ONE 8'h00
`define DSCB_RST_FEAT_TWO 8'h00

// Register override enable value
`define DSCB_REG_OVERRIDE 8'h01

// Field positions
`define DSCB_BIT_OVERRIDE 0
`define DSCB_BIT_SLEEP 1
`define DSCB_MODE_LO 2
`define DSCB_MODE_HI 3
`define DSCB_BIT_STROBE 4
`define DSCB_BIT_DATA_SLEW 5
`define DSCB_BIT_CLK_SLEW 6
`define DSCB_BIT_LOW_FREQ 7
`define DSCB_BIT_ADDR_SRC 7
`define DSCB_BIT_HOLD_REL 7
`define DSCB_BIT_SLEEP_STATE 6
`define DSCB_MAP_LO 4
`define DSCB_MAP_HI 5
`define DSCB_BIT_HOLD_BYPASS 3
`define DSCB_FCLK_HI 2
`define DSCB_BIT_EQ_EN 4
`define DSCB_EQ_LO 5
`define DSCB_EQ_HI 7

// Bus addresses chosen by the address select pin
`define DSCB_ADDR_0 7'h71
`define DSCB_ADDR_1 7'h72
`define DSCB_ADDR_2 7'h73
`define DSCB_ADDR_3 7'h76

// Power-up quiet time
`define DSCB_PWRUP_MS 10
`define DSCB_CLK_HZ 25000000

`endif

// ### tb/dscb_host_model.sv
// Bus master model driving SCL and the SDA pull-down, released SDA reads high.
// Assumes the bench merges SDA with the slave's enable and a pull-up.
`timescale 1ns/10ps
`default_nettype none
module dscb_host_model (
	// Clock
	input wire logic clk,
	// Bus lines
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Four clocks a phase: slow enough for the slave's edge detection
	task automatic ph(input logic c, input logic d);
	begin
		@(posedge clk);
		scl <= c;
		sda_drv <= d;
		repeat (3) @(posedge clk);
	end
	endtask
	task automatic start;
	begin
		// Idle bus keeps SCL still; only a repeated START needs the extra pulse
		if (!(scl && sda))
		begin
			ph(1'b0, 1'b1);
			ph(1'b1, 1'b1);
		end
		ph(1'b1, 1'b0);
	end
	endtask
	task automatic stop;
	begin
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	end
	endtask
	// Ninth bit 1 leaves room for a slave ACK or ends a read
	task automatic xb(input logic [7:0] d, input logic nack, output logic [7:0] q,
		output logic ack);
		logic [8:0] w;
		logic [8:0] s;
	begin
		w = {d, nack};
		for (int i = 8; i >= 0; i--)
		begin
			ph(1'b0, w[i]);
			ph(1'b1, w[i]);
			s[i] = sda;
		end
		q = s[8:1];
		ack = !s[0];
	end
	endtask
endmodule
`default_nettype wire

// ### tb/dscb_config_bank_properties.sv
// Checker for the bank's bus pins and setting outputs.
// Assumes it is bound onto dscb_config_bank.
`timescale 1ns/10ps
`default_nettype none
module dscb_props #(
	parameter PWRUP_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bus
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Settings
	input wire logic [1:0] mode_pin,
	input wire logic [2:0] free_clock_select_pin,
	input wire logic [1:0] mode,
	input wire logic [2:0] free_clock_select
);
	logic [31:0] up_cnt_r;
	always @(posedge clk)
		if (sys_rst)
			up_cnt_r <= 32'h0;
		else if (up_cnt_r < PWRUP_CYCLES)
			up_cnt_r <= up_cnt_r + 32'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_quiet;
		up_cnt_r < PWRUP_CYCLES |-> !sda_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("early answer");
	property p_rst;
		$fell(sys_rst) |-> mode == 2'h0 && free_clock_select == 3'h0 && !sda_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_od;
		sda_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("sda driven high");
	property p_rise;
		$rose(sda_oe) |-> !scl_in && ($past(scl_in, 2) || $past(scl_in, 3) || $past(scl_in, 4));
	endproperty
	a_rise: assert property (p_rise) else $error("late pull-down");
	property p_fall;
		$fell(sda_oe) |-> !scl_in;
	endproperty
	a_fall: assert property (p_fall) else $error("release in high");
	property p_hold;
		scl_in && $past(scl_in) |-> $stable(sda_oe);
	endproperty
	a_hold: assert property (p_hold) else $error("sda moved in high");
	property p_stop;
		scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*8];
	endproperty
	a_stop: assert property (p_stop) else $error("busy after stop");
	// Four high clocks put any register update well behind
	property p_calm;
		up_cnt_r > 32'h3 && scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)
		&& $stable(mode_pin) && $past(mode_pin, 2) == mode_pin && $stable(free_clock_select_pin)
		&& $past(free_clock_select_pin, 2) == free_clock_select_pin
		|-> $stable(mode) && $stable(free_clock_select);
	endproperty
	a_calm: assert property (p_calm) else $error("setting moved");
	c_ack: cover property (scl_in && sda_oe);
	c_stop: cover property (scl_in && $rose(sda_in));
	c_mode: cover property ($changed(mode));
endmodule
bind dscb_config_bank dscb_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_props (
	.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .mode_pin(mode_pin),
	.free_clock_select_pin(free_clock_select_pin), .mode(mode),
	.free_clock_select(free_clock_select)
);
`default_nettype wire

// ### tb/dscb_config_bank_bench.sv
// Self-checking bench for the configuration bank.
// Assumes dscb_host_model as master and a pull-up on SDA.
`timescale 1ns/10ps
`default_nettype none
module dscb_config_bank_bench;
	logic clk, sys_rst, scl, sda_drv, sda, sda_out, sda_oe, link, strap, ok;
	logic lf, cs, ds, se, slp, held, oss, ben;
	logic [1:0] asel, mode_p, mode, map;
	logic [2:0] fclk_p, fclk, boost;
	logic [6:0] pv, baddr;
	logic [7:0] q0, q1;
	int n_mismatch = 0;
	int n_checks = 0;
	assign sda = sda_drv & ~sda_oe;
	dscb_host_model host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
	dscb_config_bank #(.PWRUP_CYCLES(400)) dut (
		.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .address_select_pin(asel), .mode_pin(mode_p),
		.low_freq_spread_range_pin(pv[0]), .clock_out_slew_boost_pin(pv[1]),
		.data_out_slew_boost_pin(pv[2]), .strobe_edge_select_pin(pv[3]),
		.sleep_output_state_select_pin(pv[4]), .map_select_pin(pv[6:5]),
		.output_hold_low_strap(strap), .free_clock_select_pin(fclk_p),
		.link_acquired(link), .mode(mode), .low_freq_spread_range(lf),
		.clock_out_slew_boost(cs), .data_out_slew_boost(ds), .strobe_edge_select(se),
		.sleep_mode(slp), .outputs_held_low(held), .sleep_output_state_select(oss),
		.lsb_map_select(map), .free_clock_select(fclk), .receive_boost_level(boost),
		.receive_boost_enable(ben), .bus_address(baddr)
	);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [15:0] d,
		input logic two);
		logic [7:0] q;
		logic k1, k2, k3, k4;
	begin
		host.start();
		host.xb({a, 1'b0}, 1'b1, q, k1);
		host.xb(o, 1'b1, q, k2);
		host.xb(d[15:8], 1'b1, q, k3);
		k4 = 1'b1;
		if (two)
			host.xb(d[7:0], 1'b1, q, k4);
		host.stop();
		ok = k1 & k2 & k3 & k4;
	end
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] o);
		logic k;
	begin
		host.start();
		host.xb({a, 1'b0}, 1'b1, q0, k);
		host.xb(o, 1'b1, q0, k);
		host.start();
		host.xb({a, 1'b1}, 1'b1, q0, k);
		host.xb(8'hFF, 1'b0, q0, k);
		host.xb(8'hFF, 1'b1, q1, k);
		host.stop();
	end
	endtask
	task automatic t_early;
	begin
		wr(7'h71, 8'h00, 16'h0100, 1'b0);
		chk({7'h0, ok}, 8'h00);
		repeat (300) @(posedge clk);
	end
	endtask
	task automatic t_reset;
	begin
		pv <= 7'h2D;
		repeat (2) @(negedge clk);
		chk({1'b0, map, oss, se, ds, cs, lf}, 8'h2D);
		chk({3'h0, fclk, mode}, 8'h1A);
		rd(7'h71, 8'h00);
		chk(q0, 8'h00);
		chk(q1, 8'h70);
		wr(7'h71, 8'h04, 16'hAA00, 1'b0);
		chk({7'h0, ok}, 8'h01);
		rd(7'h71, 8'h03);
		chk(q0, 8'h00);
		chk(q1, 8'h00);
	end
	endtask
	task automatic t_addr;
		logic [6:0] tbl [4];
	begin
		tbl = '{7'h71, 7'h72, 7'h73, 7'h76};
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			asel <= i[1:0];
			wr(tbl[i], 8'h03, 16'hB000, 1'b0);
			chk({7'h0, ok}, 8'h01);
			@(negedge clk);
			chk({1'b0, baddr}, {1'b0, tbl[i]});
		end
		wr(7'h74, 8'h03, 16'h0000, 1'b0);
		chk({7'h0, ok}, 8'h00);
		asel <= 2'h0;
	end
	endtask
	task automatic t_cfg;
		logic [7:0] v [4];
	begin
		v = '{8'h01, 8'h55, 8'h89, 8'hFF};
		for (int i = 0; i < 4; i++)
		begin
			wr(7'h71, 8'h00, {v[i], 8'h00}, 1'b0);
			@(negedge clk);
			chk({lf, cs, ds, se, mode, slp, 1'b1}, v[i]);
		end
		chk({boost, ben, 4'h0}, 8'hB0);
	end
	endtask
	task automatic t_feat;
	begin
		@(posedge clk);
		link <= 1'b1;
		strap <= 1'b1;
		wr(7'h71, 8'h02, 16'h7D50, 1'b1);
		@(negedge clk);
		chk({1'b0, oss, map, held, fclk}, 8'h75);
		chk({boost, ben, 4'h0}, 8'h50);
		rd(7'h71, 8'h02);
		chk(q0, 8'h7D);
		chk(q1, 8'h50);
		wr(7'h71, 8'h02, 16'h0000, 1'b0);
		@(negedge clk);
		chk({7'h0, held}, 8'h01);
		wr(7'h71, 8'h02, 16'h8000, 1'b0);
		@(negedge clk);
		chk({7'h0, held}, 8'h00);
		@(posedge clk);
		link <= 1'b0;
		repeat (3) @(negedge clk);
		chk({7'h0, held}, 8'h01);
		wr(7'h71, 8'h02, 16'h0000, 1'b0);
		wr(7'h71, 8'h02, 16'h8000, 1'b0);
		@(negedge clk);
		chk({7'h0, held}, 8'h01);
	end
	endtask
	task automatic t_src;
	begin
		wr(7'h71, 8'h01, 16'hB500, 1'b0);
		@(negedge clk);
		chk({1'b0, baddr}, 8'h35);
		wr(7'h35, 8'h01, 16'h7000, 1'b0);
		chk({7'h0, ok}, 8'h01);
		@(negedge clk);
		chk({1'b0, baddr}, 8'h71);
	end
	endtask
	task automatic summarize;
	begin
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		sys_rst = 1'b1;
		{asel, mode_p, fclk_p, pv, link, strap} = {2'h0, 2'h2, 3'h6, 7'h0, 2'h0};
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_early;
		t_reset;
		t_addr;
		t_cfg;
		t_feat;
		t_src;
		summarize;
	end
	// Whole run needs under 10000 clocks
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		summarize;
	end
endmodule
`default_nettype wire
